// ### pkg/alarm_pkg.sv
package alarm_pkg;

  // Bit offsets in the coil-style control and status areas.
  localparam int unsigned TRIG_BASE        = 128;
  localparam int unsigned TRIG_STRIDE      = 8;
  localparam int unsigned STAT_BASE        = 544;
  localparam int unsigned STAT_STRIDE      = 16;
  localparam int unsigned STAT_GROUP_BITS  = 16;

  // Positions inside one station status group.
  localparam int unsigned ST_ONLINE        = 0;
  localparam int unsigned ST_EXCHANGE      = 1;
  localparam int unsigned ST_IDENT_BAD     = 2;
  localparam int unsigned ST_DISABLED      = 3;
  localparam int unsigned ST_DEV_ERROR     = 4;
  localparam int unsigned ST_ALARM_PEND    = 5;
  localparam int unsigned ST_DIAG_PEND     = 6;
  localparam int unsigned ST_ADDR_BAD      = 7;
  localparam int unsigned ST_CRC_BAD       = 8;
  localparam int unsigned ST_CLEAR_MODE    = 9;
  localparam int unsigned ST_ACK           = 10;

  // Alarm record word offsets in holding registers.
  localparam logic [15:0] ALARM_LENGTH_AND_TYPE    = 16'h0000;
  localparam logic [15:0] ALARM_SLOT_AND_SPECIFIER = 16'h0001;
  localparam logic [15:0] ALARM_PAYLOAD_START      = 16'h0002;

  // Example alarm type and specifier codes.
  localparam logic [7:0] TYPE_DIAGNOSIS  = 8'h01;
  localparam logic [7:0] TYPE_PULL       = 8'h03;
  localparam logic [7:0] TYPE_PLUG       = 8'h04;
  localparam logic [7:0] SPEC_NONE       = 8'h00;
  localparam logic [7:0] SPEC_APPEARED   = 8'h01;
  localparam logic [7:0] SPEC_GONE_OK    = 8'h02;
  localparam logic [7:0] SPEC_GONE_OTHER = 8'h03;

  // Peer status byte: online in bit 0, the rest reserved zero.
  localparam int unsigned PEER_ONLINE_BIT = 0;

  // Per-station link flags coming from the fieldbus engine.
  typedef struct packed {
    logic online;
    logic exchange;
    logic ident_bad;
    logic disabled;
    logic dev_error;
    logic addr_bad;
    logic crc_bad;
    logic clear_mode;
  } link_flags_t;

  // Decoded alarm header.
  typedef struct packed {
    logic [7:0] specifier;
    logic [7:0] slot;
    logic [7:0] alarm_type;
    logic [7:0] length;
  } alarm_head_t;

  typedef enum logic [3:0] {
    S_IDLE  = 4'b0001,
    S_HEAD  = 4'b0010,
    S_BODY  = 4'b0100,
    S_WAIT  = 4'b1000
  } fetch_state_t;

endpackage : alarm_pkg

// ### core/rise_detect.sv
`timescale 1ns/1ps
`default_nettype none

module rise_detect #(
  parameter int unsigned WIDTH = 4
) (
  // Clock and reset.
  input  wire logic             clk,
  input  wire logic             rst,
  // Levels to watch.
  input  wire logic [WIDTH-1:0] level,
  // One-cycle pulse per rising level.
  output var  logic [WIDTH-1:0] rise
);

  logic [WIDTH-1:0] last;
  logic [WIDTH-1:0] next_last;
  logic [WIDTH-1:0] next_rise;

  // Only a 0-to-1 change pulses; steady or falling levels do not.
  always_comb begin
    next_last = level;
    next_rise = level & ~last;
  end

  // Register history and pulse.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      last <= '0;
      rise <= '0;
    end else begin
      last <= next_last;
      rise <= next_rise;
    end
  end

endmodule : rise_detect

`default_nettype wire

// ### core/slave_alarm.sv
// Function
// - Each station's alarm raise bit sits at control bit 128 plus eight times the address.
// - Only a 0-to-1 change of the raise bit raises an alarm.
// - A raised alarm fetches its record from holding registers into station diagnostics.
// - A master acknowledge sets the station's alarm acknowledged flag.
// - Status group starts at bit 544 plus sixteen per station, bits 0-3 are link flags.
// - Device error, alarm pending and diagnostics pending sit at 548, 549 and 550.
// - Address mismatch, checksum mismatch, clear mode and acknowledge sit at 551 to 554.
// - Record word 0 holds length low and type high; payload starts at word 2.
// - Record word 1 holds slot low and specifier high.
// - Each explicit peer has a status byte with online in bit 0, other bits zero.
// - Only one alarm is outstanding until it is acknowledged.
// - Alarms work only in slave mode; trigger bits do nothing in master mode.
`timescale 1ns/1ps
`default_nettype none

module slave_alarm #(
  parameter int unsigned STATIONS   = 4,
  parameter int unsigned PEERS      = 5,
  parameter int unsigned MAX_WORDS  = 63,
  parameter int unsigned HR_AW      = 16,
  localparam int unsigned TOP_CTRL  = alarm_pkg::TRIG_BASE + alarm_pkg::TRIG_STRIDE * STATIONS,
  localparam int unsigned TOP_STAT  = alarm_pkg::STAT_BASE + alarm_pkg::STAT_STRIDE * STATIONS
) (
  // Clock and reset.
  input  wire logic                           clk,
  input  wire logic                           rst,
  // Mode: high when configured as fieldbus slave.
  input  wire logic                           slave_mode,
  // Control bit area written by the host, one bit per coil.
  input  wire logic [TOP_CTRL-1:0]            control_bits,
  // Holding register read port, data valid the cycle after the address.
  input  wire logic [HR_AW-1:0]               alarm_base,
  output var  logic [HR_AW-1:0]               hr_addr,
  input  wire logic [15:0]                    hr_data,
  // Per-station flags from the fieldbus engine.
  input  wire alarm_pkg::link_flags_t [STATIONS-1:0] link_flags,
  // Master acknowledge pulse per station.
  input  wire logic [STATIONS-1:0]            master_ack,
  // Diagnostics posted toward the master.
  output var  logic                           diag_valid,
  output var  logic [$clog2(STATIONS)-1:0]    diag_station,
  output var  alarm_pkg::alarm_head_t         diag_head,
  output var  logic [15:0]                    diag_word,
  output var  logic                           diag_word_valid,
  // Status bit area read by the host.
  output var  logic [TOP_STAT-1:0]            status_bits,
  // Explicit peer online levels and their status bytes.
  input  wire logic [PEERS-1:0]               peer_online,
  output var  logic [PEERS*8-1:0]             peer_link_state
);

  localparam int unsigned SW       = $clog2(STATIONS);

  logic [STATIONS-1:0] trig_level;
  logic [STATIONS-1:0] trig_rise;
  logic [PEERS-1:0]    peer_s1;
  logic [PEERS-1:0]    peer_s2;

  // Gather raise bits from the control area.
  for (genvar s = 0; s < STATIONS; s++) begin : g_trig
    assign trig_level[s] = control_bits[alarm_pkg::TRIG_BASE + alarm_pkg::TRIG_STRIDE * s];
  end

  rise_detect #(.WIDTH(STATIONS)) u_rise (
    .clk   (clk),
    .rst   (rst),
    .level (trig_level),
    .rise  (trig_rise)
  );

  alarm_pkg::fetch_state_t state;
  alarm_pkg::fetch_state_t next_state;
  logic [SW-1:0]           cur;
  logic [SW-1:0]           next_cur;
  logic [7:0]              left;
  logic [7:0]              next_left;
  logic [HR_AW-1:0]        next_hr_addr;
  alarm_pkg::alarm_head_t  next_head;
  logic                    next_diag_valid;
  logic [15:0]             next_diag_word;
  logic                    next_word_valid;
  logic [STATIONS-1:0]     pend;
  logic [STATIONS-1:0]     next_pend;
  logic [STATIONS-1:0]     ack;
  logic [STATIONS-1:0]     next_ack;
  logic                    half;
  logic                    next_half;
  logic [SW-1:0]           pick;
  logic                    any_rise;

  // Lowest-numbered rising station wins; others wait for the next edge.
  always_comb begin
    pick = '0;
    any_rise = 1'b0;
    for (int i = STATIONS - 1; i >= 0; i--) begin
      if (trig_rise[i]) begin
        pick = SW'(i);
        any_rise = 1'b1;
      end
    end
  end

  // Fetch sequencer: header words, then payload words, then wait for ack.
  always_comb begin
    next_state      = state;
    next_cur        = cur;
    next_left       = left;
    next_hr_addr    = hr_addr;
    next_head       = diag_head;
    next_diag_valid = diag_valid;
    next_diag_word  = diag_word;
    next_word_valid = 1'b0;
    next_pend       = pend;
    next_ack        = ack;
    next_half       = half;
    unique case (state)
      alarm_pkg::S_IDLE: begin
        if (slave_mode && any_rise) begin
          next_cur = pick;
          next_hr_addr = alarm_base + HR_AW'(alarm_pkg::ALARM_LENGTH_AND_TYPE);
          next_pend[pick] = 1'b1;
          next_ack[pick] = 1'b0;
          next_half = 1'b0;
          next_state = alarm_pkg::S_HEAD;
        end
      end
      alarm_pkg::S_HEAD: begin
        // Read data answers the address of the previous cycle, so word 0 is here first.
        if (!half) begin
          next_head.length = hr_data[7:0];
          next_head.alarm_type = hr_data[15:8];
          next_left = hr_data[7:0];
          next_hr_addr = alarm_base + HR_AW'(alarm_pkg::ALARM_SLOT_AND_SPECIFIER);
          next_half = 1'b1;
        end else begin
          next_head.slot = hr_data[7:0];
          next_head.specifier = hr_data[15:8];
          next_hr_addr = alarm_base + HR_AW'(alarm_pkg::ALARM_PAYLOAD_START);
          next_half = 1'b0;
          if (left == 8'h00) begin
            next_diag_valid = 1'b1;
            next_state = alarm_pkg::S_WAIT;
          end else begin
            next_state = alarm_pkg::S_BODY;
          end
        end
      end
      alarm_pkg::S_BODY: begin
        next_diag_word = hr_data;
        next_word_valid = 1'b1;
        next_hr_addr = hr_addr + HR_AW'(1);
        if (left <= 8'h02) begin
          next_left = 8'h00;
          next_diag_valid = 1'b1;
          next_state = alarm_pkg::S_WAIT;
        end else begin
          next_left = left - 8'h02;
        end
      end
      alarm_pkg::S_WAIT: begin
        if (master_ack[cur]) begin
          next_pend[cur] = 1'b0;
          next_ack[cur] = 1'b1;
          next_diag_valid = 1'b0;
          next_state = alarm_pkg::S_IDLE;
        end
      end
    endcase
  end

  // Fetch sequencer registers.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state        <= alarm_pkg::S_IDLE;
      cur          <= '0;
      left         <= 8'h00;
      hr_addr      <= '0;
      diag_head    <= '0;
      diag_valid   <= 1'b0;
      diag_word    <= 16'h0000;
      diag_word_valid <= 1'b0;
      pend         <= '0;
      ack          <= '0;
      half         <= 1'b0;
    end else begin
      state        <= next_state;
      cur          <= next_cur;
      left         <= next_left;
      hr_addr      <= next_hr_addr;
      diag_head    <= next_head;
      diag_valid   <= next_diag_valid;
      diag_word    <= next_diag_word;
      diag_word_valid <= next_word_valid;
      pend         <= next_pend;
      ack          <= next_ack;
      half         <= next_half;
    end
  end

  assign diag_station = cur;

  logic [TOP_STAT-1:0]  next_status;
  logic [PEERS*8-1:0]   next_peer;

  // Build the status area and peer bytes.
  always_comb begin
    next_status = '0;
    for (int s = 0; s < STATIONS; s++) begin
      next_status[alarm_pkg::STAT_BASE + alarm_pkg::STAT_STRIDE*s + alarm_pkg::ST_ONLINE]
        = link_flags[s].online;
      next_status[alarm_pkg::STAT_BASE + alarm_pkg::STAT_STRIDE*s + alarm_pkg::ST_EXCHANGE]
        = link_flags[s].exchange;
      next_status[alarm_pkg::STAT_BASE + alarm_pkg::STAT_STRIDE*s + alarm_pkg::ST_IDENT_BAD]
        = link_flags[s].ident_bad;
      next_status[alarm_pkg::STAT_BASE + alarm_pkg::STAT_STRIDE*s + alarm_pkg::ST_DISABLED]
        = link_flags[s].disabled;
      next_status[alarm_pkg::STAT_BASE + alarm_pkg::STAT_STRIDE*s + alarm_pkg::ST_DEV_ERROR]
        = link_flags[s].dev_error;
      next_status[alarm_pkg::STAT_BASE + alarm_pkg::STAT_STRIDE*s + alarm_pkg::ST_ALARM_PEND]
        = pend[s];
      next_status[alarm_pkg::STAT_BASE + alarm_pkg::STAT_STRIDE*s + alarm_pkg::ST_DIAG_PEND]
        = pend[s];
      next_status[alarm_pkg::STAT_BASE + alarm_pkg::STAT_STRIDE*s + alarm_pkg::ST_ADDR_BAD]
        = link_flags[s].addr_bad;
      next_status[alarm_pkg::STAT_BASE + alarm_pkg::STAT_STRIDE*s + alarm_pkg::ST_CRC_BAD]
        = link_flags[s].crc_bad;
      next_status[alarm_pkg::STAT_BASE + alarm_pkg::STAT_STRIDE*s + alarm_pkg::ST_CLEAR_MODE]
        = link_flags[s].clear_mode;
      next_status[alarm_pkg::STAT_BASE + alarm_pkg::STAT_STRIDE*s + alarm_pkg::ST_ACK]
        = ack[s];
    end
    next_peer = '0;
    for (int p = 0; p < PEERS; p++) begin
      next_peer[p*8 + alarm_pkg::PEER_ONLINE_BIT] = peer_s2[p];
    end
  end

  // Status registers; peer levels pass a two-stage synchroniser.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      status_bits     <= '0;
      peer_link_state <= '0;
      peer_s1         <= '0;
      peer_s2         <= '0;
    end else begin
      status_bits     <= next_status;
      peer_link_state <= next_peer;
      peer_s1         <= peer_online;
      peer_s2         <= peer_s1;
    end
  end

endmodule : slave_alarm

`default_nettype wire

// ### tb/dp_master_model.sv
`timescale 1ns/1ps
`default_nettype none

module dp_master_model #(
  parameter int unsigned STATIONS = 4
) (
  // Clock and reset.
  input  wire logic                        clk,
  input  wire logic                        rst,
  // Posted record and chosen reply delay.
  input  wire logic                        diag_valid,
  input  wire logic [$clog2(STATIONS)-1:0] diag_station,
  input  wire logic [7:0]                  ack_delay,
  // Acknowledge pulse toward the device.
  output logic [STATIONS-1:0]              master_ack
);
  logic [7:0] waited;

  // Waits the given delay after a posted record, then acknowledges it once.
  always @(negedge clk or posedge rst) begin
    if (rst) begin
      master_ack <= '0;
      waited     <= '0;
    end else begin
      master_ack <= '0;
      if (diag_valid && master_ack == '0 && waited >= ack_delay) begin
        master_ack[diag_station] <= 1'b1;
        waited                   <= '0;
      end else if (diag_valid && master_ack == '0) begin
        waited <= waited + 8'h01;
      end
    end
  end
endmodule : dp_master_model

`default_nettype wire

// ### tb/slave_alarm_properties.sv
`timescale 1ns/1ps
`default_nettype none

module slave_alarm_properties #(
  parameter int unsigned STATIONS = 4,
  parameter int unsigned PEERS    = 5,
  parameter int unsigned HR_AW    = 16,
  localparam int unsigned TOP_CTRL = 128 + 8 * STATIONS,
  localparam int unsigned TOP_STAT = 544 + 16 * STATIONS
) (
  // Watched ports.
  input wire logic                                  clk,
  input wire logic                                  rst,
  input wire logic                                  slave_mode,
  input wire logic [TOP_CTRL-1:0]                   control_bits,
  input wire logic [HR_AW-1:0]                      alarm_base,
  input wire logic [HR_AW-1:0]                      hr_addr,
  input wire alarm_pkg::link_flags_t [STATIONS-1:0] link_flags,
  input wire logic [STATIONS-1:0]                   master_ack,
  input wire logic                                  diag_valid,
  input wire logic [$clog2(STATIONS)-1:0]           diag_station,
  input wire alarm_pkg::alarm_head_t                diag_head,
  input wire logic                                  diag_word_valid,
  input wire logic [TOP_STAT-1:0]                   status_bits,
  input wire logic [PEERS-1:0]                      peer_online,
  input wire logic [PEERS*8-1:0]                    peer_link_state
);
  logic       pend_any;
  logic       busy;
  logic [8:0] words;

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  // Any station pending means the fetch engine is occupied.
  always_comb begin
    pend_any = 1'b0;
    for (int k = 0; k < STATIONS; k++) begin
      pend_any = pend_any | status_bits[549+16*k];
    end
    busy = pend_any | diag_valid;
  end

  // Counts payload words posted before the record is declared valid.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      words <= '0;
    end else if (diag_valid) begin
      words <= '0;
    end else if (diag_word_valid) begin
      words <= words + 9'h001;
    end
  end

  sequence s_quiet_raise;
    (!busy && !control_bits[128] && slave_mode) [*3] ##1 (control_bits[128] && slave_mode);
  endsequence

  a_fetch_walk: assert property (s_quiet_raise |-> ##[1:3] (hr_addr == alarm_base) ##1 (hr_addr == alarm_base + 1'b1))
    else $error("record fetch did not start at the base address");
  a_ack_flag: assert property (diag_valid && diag_station == 0 && master_ack[0] |-> ##[1:3] (status_bits[554] && !status_bits[549]))
    else $error("acknowledge flag not raised");
  a_pend_mirror: assert property (status_bits[549] == status_bits[550])
    else $error("diagnostics pending differs from alarm pending");
  a_link_low: assert property (!$past(rst) |-> status_bits[548:544] == $past({link_flags[0].dev_error, link_flags[0].disabled, link_flags[0].ident_bad, link_flags[0].exchange, link_flags[0].online}))
    else $error("low status bits wrong");
  a_link_high: assert property (!$past(rst) |-> status_bits[553:551] == $past({link_flags[0].clear_mode, link_flags[0].crc_bad, link_flags[0].addr_bad}))
    else $error("high status bits wrong");
  a_peer_byte: assert property ($stable(peer_online[0]) [*6] |-> peer_link_state[7:0] == {7'h00, peer_online[0]})
    else $error("peer status byte wrong");
  a_master_mode: assert property (!slave_mode [*6] |-> !$rose(pend_any))
    else $error("alarm taken in master mode");
  a_one_out: assert property (diag_valid && !master_ack[diag_station] |=> diag_valid && $stable(diag_station) && $stable(diag_head))
    else $error("outstanding alarm changed before acknowledge");
  a_word_count: assert property ($rose(diag_valid) |-> words + {8'h00, diag_word_valid} == ({1'b0, diag_head.length} + 9'h001) >> 1)
    else $error("payload word count wrong");
endmodule : slave_alarm_properties

bind slave_alarm slave_alarm_properties #(.STATIONS(STATIONS), .PEERS(PEERS), .HR_AW(HR_AW)) props (
  .clk(clk), .rst(rst), .slave_mode(slave_mode), .control_bits(control_bits),
  .alarm_base(alarm_base), .hr_addr(hr_addr), .link_flags(link_flags), .master_ack(master_ack),
  .diag_valid(diag_valid), .diag_station(diag_station), .diag_head(diag_head),
  .diag_word_valid(diag_word_valid), .status_bits(status_bits), .peer_online(peer_online),
  .peer_link_state(peer_link_state));

`default_nettype wire

// ### tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none

module testbench;
  localparam logic [7:0] TYPES [3] = '{alarm_pkg::TYPE_DIAGNOSIS, alarm_pkg::TYPE_PULL, alarm_pkg::TYPE_PLUG};
  logic clk, rst, slave_mode, diag_valid, diag_word_valid;
  logic [159:0] control_bits;
  logic [15:0] alarm_base, hr_addr, hr_data, diag_word;
  alarm_pkg::link_flags_t [3:0] link_flags;
  logic [3:0] master_ack;
  logic [1:0] diag_station;
  logic [7:0] ack_delay;
  alarm_pkg::alarm_head_t diag_head;
  logic [607:0] status_bits;
  logic [4:0] peer_online;
  logic [39:0] peer_link_state;
  logic [15:0] mem [128];
  logic [31:0] seed = 32'h0001_104D;
  int error_cnt = 0;
  int checked = 0;
  int widx = 0;

  slave_alarm #(.STATIONS(4), .PEERS(5), .MAX_WORDS(63), .HR_AW(16)) dut (
    .clk(clk), .rst(rst), .slave_mode(slave_mode), .control_bits(control_bits),
    .alarm_base(alarm_base), .hr_addr(hr_addr), .hr_data(hr_data), .link_flags(link_flags),
    .master_ack(master_ack), .diag_valid(diag_valid), .diag_station(diag_station),
    .diag_head(diag_head), .diag_word(diag_word), .diag_word_valid(diag_word_valid),
    .status_bits(status_bits), .peer_online(peer_online), .peer_link_state(peer_link_state));
  dp_master_model #(.STATIONS(4)) master (.clk(clk), .rst(rst), .diag_valid(diag_valid),
    .diag_station(diag_station), .ack_delay(ack_delay), .master_ack(master_ack));

  function automatic logic [31:0] xorshift(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xorshift

  function automatic logic [15:0] exp_group(input alarm_pkg::link_flags_t f, input logic p, input logic a);
    return {5'h00, a, f.clear_mode, f.crc_bad, f.addr_bad, p, p, f.dev_error, f.disabled, f.ident_bad, f.exchange, f.online};
  endfunction : exp_group

  task automatic check(input logic ok, input string msg);
    checked++;
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask : check

  task automatic tally_and_finish;
    if (error_cnt == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : tally_and_finish

  // Posts one record, optionally tries a second station while busy, waits for acknowledge.
  task automatic raise(input int s, input int len, input int o, input int i);
    int k;
    mem[0] = {TYPES[i%3], 8'(len)};
    mem[1] = {8'(i % 4), seed[7:0]};
    for (k = 2; k < 128; k++) begin
      mem[k] = seed[31:16] ^ 16'(k);
    end
    widx = 0;
    repeat (4) @(negedge clk);
    control_bits[128+8*s] = 1'b1;
    for (k = 0; diag_valid !== 1'b1 && k < 200; k++) @(negedge clk);
    check(diag_valid === 1'b1 && diag_station === 2'(s) && diag_head === {mem[1], mem[0]}, "posted header");
    check(status_bits[544+16*s +: 16] === exp_group(link_flags[s], 1'b1, 1'b0), "busy group");
    if (o >= 0) control_bits[128+8*o] = 1'b1;
    for (k = 0; status_bits[554+16*s] !== 1'b1 && k < 300; k++) @(negedge clk);
    check(widx === (len + 1) / 2, "payload word count");
    check(status_bits[544+16*s +: 16] === exp_group(link_flags[s], 1'b0, 1'b1), "idle group");
    control_bits[128+8*s] = 1'b0;
    if (o >= 0) begin
      repeat (5) @(negedge clk);
      check(status_bits[549+16*o] === 1'b0 && diag_valid === 1'b0, "busy raise taken");
      control_bits[128+8*o] = 1'b0;
      repeat (5) @(negedge clk);
      check(status_bits[549+16*o] === 1'b0, "falling bit raised alarm");
    end
  endtask : raise

  // Holding registers answer one cycle after the address; payload words are compared.
  always @(negedge clk) begin
    hr_data <= mem[7'(hr_addr - alarm_base)];
    if (diag_word_valid === 1'b1) begin
      check(diag_word === mem[widx+2], "payload word");
      widx++;
    end
  end

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  initial begin
    #2_000_000;
    error_cnt++;
    tally_and_finish;
  end

  initial begin
    int s;
    rst = 1'b1;
    slave_mode = 1'b1;
    control_bits = '0;
    alarm_base = 16'h0EB3;
    link_flags = '0;
    peer_online = '0;
    ack_delay = 8'h00;
    repeat (6) @(negedge clk);
    rst = 1'b0;
    for (int i = 0; i < 24; i++) begin
      seed = xorshift(seed);
      link_flags = seed;
      seed = xorshift(seed);
      peer_online = seed[4:0];
      s = (i < 3) ? 0 : int'(seed[17:16]);
      ack_delay = (i % 3 == 0) ? 8'(4 + seed[11:8]) : 8'(seed[10:8]);
      raise(s, (i < 2) ? i : (i == 2) ? 126 : int'(seed[23:20]) + 1, (i % 3 == 0) ? (s + 1) % 4 : -1, i);
      check(peer_link_state === {7'h00, peer_online[4], 7'h00, peer_online[3], 7'h00, peer_online[2],
            7'h00, peer_online[1], 7'h00, peer_online[0]}, "peer bytes");
    end
    slave_mode = 1'b0;
    // Let master mode settle for several cycles so the mode assertion sees a real attempt.
    repeat (8) @(negedge clk);
    control_bits[128] = 1'b1;
    repeat (10) @(negedge clk);
    check(status_bits[549] === 1'b0 && diag_valid === 1'b0, "alarm in master mode");
    tally_and_finish;
  end
endmodule : testbench

`default_nettype wire
